// >>> inc/bldc_pkg.sv
// constants and types for the supply level detector controller
// assumes a 16-bit register port with byte and word access at the system clock
`default_nettype none
package bldc_pkg;
    // =========================================================
    // register map
    localparam logic [15:0] THRESHOLD_SELECT_ADDR = 16'hf0d0;
    localparam logic [15:0] ENABLE_STATUS_ADDR    = 16'hf0d1;
    localparam logic [7:0]  THRESHOLD_RESET       = 8'h00;
    localparam logic [7:0]  ENABLE_STATUS_RESET   = 8'h00;
    // =========================================================
    // field positions
    localparam int THRESHOLD_CODE_LSB = 0;
    localparam int THRESHOLD_CODE_W   = 4;
    localparam int DETECTOR_ON_BIT    = 0;
    localparam int BELOW_FLAG_BIT     = 1;
    // =========================================================
    // timing
    localparam int CLK_PERIOD_NS      = 100;
    localparam int SETTLE_TIME_MS     = 1;
    localparam int SETTLE_CYCLES      = (SETTLE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // =========================================================
    // bus request carrier
    typedef struct packed
    {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
        logic        word;
    } bldc_req_type;
    // settling tracker states
    typedef enum logic [1:0]
    {
        BLDC_OFF      = 2'b00,
        BLDC_SETTLING = 2'b01,
        BLDC_READY    = 2'b11
    } bldc_state_type;
endpackage
`default_nettype wire

// >>> design/bldc_sync.sv
// two-stage synchroniser for one asynchronous level
// assumes the level may change at any time relative to clk
`default_nettype none
module bldc_sync
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // level
    input  wire logic async_in,
    output var  logic sync_out
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    always_comb
    begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule
`default_nettype wire

// >>> design/bldc_ctrl.sv
// register front end for the supply level detector comparator
// assumes an analog comparator outside, output asynchronous to clk
// Function
// - four-bit threshold code drives comparator reference
// - enable bit, write sets state, resets zero
// - read-only below-threshold flag at bit one
// - comparator powered down while enable is zero
// - two byte registers, word access at lower
//
// Strobed register access was decided locally.
`default_nettype none
module bldc_ctrl
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // register port
    input  wire logic [15:0]          reg_addr,
    input  wire logic [15:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic                 reg_word,
    output var  logic [15:0]          reg_rdata,
    // analog comparator side
    output var  logic [3:0]           compare_threshold_voltage,
    output var  logic                 detector_power_on,
    input  wire logic                 comparator_below_async,
    // status
    output var  logic                 detector_settled
);
    // =========================================================
    // request decode
    bldc_pkg::bldc_req_type req;
    logic hit_lo;
    logic hit_hi;
    logic lane_lo;
    logic lane_hi;
    logic [7:0] lo_data;
    logic [7:0] hi_data;

    always_comb
    begin
        req.addr  = reg_addr;
        req.wdata = reg_wdata;
        req.wr    = reg_wr;
        req.rd    = reg_rd;
        req.word  = reg_word;
        hit_lo    = (req.addr == bldc_pkg::THRESHOLD_SELECT_ADDR);
        hit_hi    = (req.addr == bldc_pkg::ENABLE_STATUS_ADDR);
        lane_lo   = hit_lo;
        lane_hi   = hit_hi || (hit_lo && req.word);
        lo_data   = req.wdata[7:0];
        hi_data   = (hit_lo && req.word) ? req.wdata[15:8] : req.wdata[7:0];
    end

    // =========================================================
    // control registers
    logic [7:0] thr_r;
    logic [7:0] thr_nxt;
    logic       on_r;
    logic       on_nxt;

    always_comb
    begin
        thr_nxt = thr_r;
        on_nxt  = on_r;
        if (req.wr && lane_lo)
        begin
            thr_nxt = lo_data;
        end
        if (req.wr && lane_hi)
        begin
            on_nxt = hi_data[bldc_pkg::DETECTOR_ON_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            thr_r <= bldc_pkg::THRESHOLD_RESET;
            on_r  <= 1'b0;
        end
        else
        begin
            thr_r <= thr_nxt;
            on_r  <= on_nxt;
        end
    end

    // =========================================================
    // comparator result path
    logic below_sync;
    logic flag_r;
    logic flag_nxt;

    bldc_sync u_sync
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (comparator_below_async),
        .sync_out (below_sync)
    );

    always_comb
    begin
        flag_nxt = on_r ? below_sync : 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_r <= 1'b0;
        end
        else
        begin
            flag_r <= flag_nxt;
        end
    end

    // =========================================================
    // settling tracker
    bldc_pkg::bldc_state_type st_r;
    bldc_pkg::bldc_state_type st_nxt;
    logic [$clog2(bldc_pkg::SETTLE_CYCLES+1)-1:0] cnt_r;
    logic [$clog2(bldc_pkg::SETTLE_CYCLES+1)-1:0] cnt_nxt;
    localparam logic [$clog2(bldc_pkg::SETTLE_CYCLES+1)-1:0] SETTLE_LAST =
        ($clog2(bldc_pkg::SETTLE_CYCLES+1))'(bldc_pkg::SETTLE_CYCLES - 1);

    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            bldc_pkg::BLDC_OFF:
            begin
                cnt_nxt = '0;
                if (on_r)
                begin
                    st_nxt = bldc_pkg::BLDC_SETTLING;
                end
            end
            bldc_pkg::BLDC_SETTLING:
            begin
                if (!on_r)
                begin
                    st_nxt = bldc_pkg::BLDC_OFF;
                end
                else if (cnt_r == SETTLE_LAST)
                begin
                    st_nxt = bldc_pkg::BLDC_READY;
                end
                else
                begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            bldc_pkg::BLDC_READY:
            begin
                if (!on_r)
                begin
                    st_nxt = bldc_pkg::BLDC_OFF;
                end
            end
            default:
            begin
                st_nxt = bldc_pkg::BLDC_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r  <= bldc_pkg::BLDC_OFF;
            cnt_r <= '0;
        end
        else
        begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // =========================================================
    // read data
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic [7:0]  lo_view;
    logic [7:0]  hi_view;

    always_comb
    begin
        lo_view = thr_r;
        hi_view = 8'h00;
        hi_view[bldc_pkg::DETECTOR_ON_BIT] = on_r;
        hi_view[bldc_pkg::BELOW_FLAG_BIT]  = flag_r;
        rdata_nxt = 16'h0000;
        if (req.rd && hit_lo)
        begin
            rdata_nxt = req.word ? {hi_view, lo_view} : {8'h00, lo_view};
        end
        else if (req.rd && hit_hi)
        begin
            rdata_nxt = {8'h00, hi_view};
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_r <= 16'h0000;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // =========================================================
    // outputs
    assign reg_rdata                 = rdata_r;
    assign compare_threshold_voltage = thr_r[bldc_pkg::THRESHOLD_CODE_LSB +: bldc_pkg::THRESHOLD_CODE_W];
    assign detector_power_on         = on_r;
    assign detector_settled          = (st_r == bldc_pkg::BLDC_READY);
endmodule
`default_nettype wire

// >>> testbench/bldc_ctrl_checker.sv
// port assertions for the detector register front end
// assumes the port timing of bldc_ctrl, reads answered one cycle on
`default_nettype none
module bldc_ctrl_checker
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        reg_word,
    input wire logic [15:0] reg_rdata,
    // comparator side and status
    input wire logic [3:0]  compare_threshold_voltage,
    input wire logic        detector_power_on,
    input wire logic        comparator_below_async,
    input wire logic        detector_settled
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // =========================================================
    // assertions
    chk_thr_write: assert property (reg_wr && reg_addr == 16'hf0d0 |=>
        compare_threshold_voltage == $past(reg_wdata[3:0])) else $error("threshold not written");
    chk_en_write: assert property (reg_wr && reg_addr == 16'hf0d1 |=>
        detector_power_on == $past(reg_wdata[0])) else $error("enable not written");
    chk_word_en: assert property (reg_wr && reg_addr == 16'hf0d0 && reg_word |=>
        detector_power_on == $past(reg_wdata[8])) else $error("word write high byte lost");
    chk_en_hold: assert property (!reg_wr |=> $stable(detector_power_on))
        else $error("enable moved without write");
    chk_rd_status: assert property (reg_rd && reg_addr == 16'hf0d1 |=>
        reg_rdata[0] == $past(detector_power_on) && reg_rdata[15:2] == 14'h0000) else $error("status read bad");
    chk_flag_off: assert property (reg_rd && reg_addr == 16'hf0d1 && !detector_power_on &&
        !$past(detector_power_on) |=> !reg_rdata[1]) else $error("flag set while off");
    chk_rd_thr: assert property (reg_rd && reg_addr == 16'hf0d0 && !reg_word |=>
        reg_rdata[3:0] == $past(compare_threshold_voltage) && reg_rdata[15:8] == 8'h00) else $error("threshold read bad");
    chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
    chk_settle_off: assert property (!detector_power_on |=> !detector_settled)
        else $error("settled while off");
    chk_flag_follow: assert property (reg_rd && reg_addr == 16'hf0d1 && $past(detector_power_on) |=>
        reg_rdata[1] == $past(comparator_below_async, 4)) else $error("flag does not follow comparator");
    chk_word_rd: assert property (reg_rd && reg_addr == 16'hf0d0 && reg_word |=>
        reg_rdata[3:0] == $past(compare_threshold_voltage) && reg_rdata[8] == $past(detector_power_on) &&
        reg_rdata[15:10] == 6'h00) else $error("word read bad");
endmodule
bind bldc_ctrl bldc_ctrl_checker bldc_ctrl_checker_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_word(reg_word), .reg_rdata(reg_rdata),
    .compare_threshold_voltage(compare_threshold_voltage), .detector_power_on(detector_power_on),
    .comparator_below_async(comparator_below_async), .detector_settled(detector_settled));
`default_nettype wire

// >>> testbench/bldc_comparator_model.sv
// comparator and reference ladder stand-in
// assumes supply level given as a code on the threshold scale
`default_nettype none
module bldc_comparator_model
(
    // control from block
    input  wire logic [3:0] threshold,
    input  wire logic       power_on,
    // supply and result
    input  wire logic [3:0] supply_code,
    output var  logic       below
);
    timeunit 1ns;
    timeprecision 1ns;
    // powered down output is meaningless: shown inverted
    assign below = power_on ? (supply_code < threshold) : (supply_code >= threshold);
endmodule
`default_nettype wire

// >>> testbench/battery_level_detector_ctrl_bench.sv
// self-checking bench for bldc_ctrl with comparator model
// assumes 10 MHz clock and settle count of 10000 cycles
`default_nettype none
module battery_level_detector_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [15:0] a; logic [15:0] w; logic wd; logic [15:0] e;} bldc_row_type;
    logic         clk, rst_n, reg_wr, reg_rd, reg_word, below, on, settled;
    logic [15:0]  reg_addr, reg_wdata, reg_rdata, d;
    logic [3:0]   thr, supply;
    int           errors = 0, cmp_count = 0, cyc = 0, i;
    bldc_row_type rows [5] = '{'{16'hf0d0, 16'h00a5, 1'b0, 16'h00a5}, '{16'hf0d1, 16'h00ff, 1'b0, 16'h0001},
        '{16'hf0d1, 16'h00fe, 1'b0, 16'h0000}, '{16'hf0d2, 16'h00ff, 1'b0, 16'h0000},
        '{16'hf0d0, 16'h0007, 1'b1, 16'h0007}};
    bldc_ctrl bldc_ctrl_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_word(reg_word), .reg_rdata(reg_rdata),
        .compare_threshold_voltage(thr), .detector_power_on(on), .comparator_below_async(below),
        .detector_settled(settled));
    bldc_comparator_model bldc_comparator_model_inst (.threshold(thr), .power_on(on), .supply_code(supply),
        .below(below));
    // =========================================================
    // clock, timeout, tasks
    initial
    begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            final_report();
        end
    end
    task final_report();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [15:0] a, input logic [15:0] w, input logic wd);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= w; reg_word <= wd; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [15:0] a, input logic wd, output logic [15:0] q);
        @(posedge clk);
        reg_addr <= a; reg_word <= wd; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    // =========================================================
    // main sequence
    initial
    begin
        rst_n = 0; reg_wr = 0; reg_rd = 0; reg_word = 0; reg_addr = 0; reg_wdata = 0; supply = 4'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(16'hf0d0, 1'b0, d); check(d, 16'h0000);
        rd(16'hf0d1, 1'b0, d); check(d, 16'h0000);
        for (i = 0; i < 5; i++)
        begin
            wr(rows[i].a, rows[i].w, rows[i].wd);
            rd(rows[i].a, rows[i].wd, d); check(d, rows[i].e);
        end
        for (i = 0; i < 16; i++)
        begin
            wr(16'hf0d0, i[15:0], 1'b0); check({12'h000, thr}, i[15:0]);
        end
        wr(16'hf0d0, 16'h0008, 1'b0);
        supply = 4'h3;
        rd(16'hf0d1, 1'b0, d); check(d, 16'h0000);
        wr(16'hf0d1, 16'h0001, 1'b0);
        i = 0;
        while (settled !== 1'b1 && i < 10010)
        begin
            @(posedge clk);
            #1;
            i++;
        end
        check(16'(i >= bldc_pkg::SETTLE_CYCLES), 16'h0001);
        check({15'h0000, settled}, 16'h0001);
        rd(16'hf0d1, 1'b0, d); check(d, 16'h0003);
        rd(16'hf0d0, 1'b1, d); check(d, 16'h0308);
        supply = 4'hc;
        repeat (5) @(posedge clk);
        rd(16'hf0d1, 1'b0, d); check(d, 16'h0001);
        wr(16'hf0d1, 16'h0003, 1'b0);
        rd(16'hf0d1, 1'b0, d); check(d, 16'h0001);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(16'hf0d1, 1'b0, d); check(d, 16'h0000);
        rd(16'hf0d0, 1'b0, d); check(d, 16'h0000);
        check({15'h0000, on}, 16'h0000);
        final_report();
    end
endmodule
`default_nettype wire
